// *** shared/dbtc_pkg.sv ***
package dbtc_pkg;
	localparam int DBTC_DATA_W = 64;
	localparam int DBTC_LANES = 8;
	localparam int DBTC_LANE_W = 8;
	localparam int DBTC_QDEPTH = 4;
	localparam int DBTC_TAG_W = 4;
	localparam int DBTC_BEAT_W = 2;
	localparam logic [1:0] DBTC_BURST_LAST = 2'h3;
	localparam logic [1:0] DBTC_SINGLE_LAST = 2'h0;
	localparam logic [1:0] DBTC_BEAT_FIRST = 2'h0;
	localparam logic [1:0] DBTC_BEAT_STEP = 2'h1;
	localparam logic [63:0] DBTC_DATA_RST = 64'h0;
	localparam logic [7:0] DBTC_PAR_RST = 8'h0;

	typedef enum logic [1:0] {
		DBTC_IDLE,
		DBTC_BUSY,
		DBTC_RELEASE
	} dbtc_state_t;

	// one pending data tenure, queued at its transfer start
	typedef struct packed {
		logic isWrite;
		logic isBurst;
		logic [DBTC_TAG_W-1:0] tag;
	} dbtc_ent_t;

	// bus inputs, all active low
	typedef struct packed {
		logic grantN;
		logic writeOnlyN;
		logic busyN;
		logic dataRetryN;
		logic addrRetryN;
		logic startN;
		logic ackN;
		logic errAckN;
		logic disableN;
	} dbtc_busin_t;
endpackage : dbtc_pkg

// *** design/dbtc_lane_parity.sv ***
`timescale 1ns/1ns
module dbtc_lane_parity #(
	parameter int LANES = dbtc_pkg::DBTC_LANES,
	parameter int LANE_W = dbtc_pkg::DBTC_LANE_W
) (
	input wire logic [LANES*LANE_W-1:0] genData,
	input wire logic [LANES*LANE_W-1:0] chkData,
	input wire logic [LANES-1:0] chkPar,
	output logic [LANES-1:0] genPar,
	output logic [LANES-1:0] laneErr
);
	import dbtc_pkg::*;

	// lane k sits at the top end: lane 0 is the most significant byte
	for (genvar k = 0; k < LANES; k++) begin : gLane
		localparam int HI = LANES*LANE_W - 1 - k*LANE_W;
		assign genPar[k] = ~^genData[HI -: LANE_W];
		assign laneErr[k] = ~^{chkData[HI -: LANE_W], chkPar[k]};
	end
endmodule : dbtc_lane_parity

// *** design/dbtc_tenure.sv ***
`timescale 1ns/1ns
module dbtc_tenure #(
	parameter int QDEPTH = dbtc_pkg::DBTC_QDEPTH,
	parameter int TAG_W = dbtc_pkg::DBTC_TAG_W
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire dbtc_pkg::dbtc_busin_t busIn,
	input wire logic [dbtc_pkg::DBTC_DATA_W-1:0] dataIn,
	input wire logic [dbtc_pkg::DBTC_LANES-1:0] parityIn,
	output logic [dbtc_pkg::DBTC_DATA_W-1:0] dataOut,
	output logic dataOe,
	output logic [dbtc_pkg::DBTC_LANES-1:0] parityOut,
	output logic parityOe,
	output logic dataBusyOutN,
	output logic dataBusyOe,
	input wire logic coreTsMine,
	input wire logic coreTsWrite,
	input wire logic coreTsBurst,
	input wire logic [TAG_W-1:0] coreTag,
	input wire logic [dbtc_pkg::DBTC_DATA_W-1:0] coreWrData,
	input wire logic parityGenEn,
	input wire logic parityChkEn,
	output logic [TAG_W-1:0] wrTag,
	output logic [dbtc_pkg::DBTC_BEAT_W-1:0] wrBeat,
	output logic [TAG_W-1:0] actTag,
	output logic [dbtc_pkg::DBTC_DATA_W-1:0] rdData,
	output logic rdValid,
	output logic rdRetry,
	output logic tenureDone,
	output logic tenureErr,
	output logic tenureRetry,
	output logic queueFull,
	output logic checkstop
);
	import dbtc_pkg::*;

	dbtc_state_t state_reg;
	logic [QDEPTH-1:0] valid_reg;
	dbtc_ent_t ent_reg [QDEPTH];
	logic [QDEPTH-1:0] shV;
	dbtc_ent_t shE [QDEPTH];
	logic [QDEPTH-1:0] valid_next;
	dbtc_ent_t ent_next [QDEPTH];
	logic actWrite_reg;
	logic actBurst_reg;
	logic [DBTC_BEAT_W-1:0] beat_reg;
	logic [TAG_W-1:0] wrTag_reg;
	logic [DBTC_BEAT_W-1:0] wrBeat_reg;
	logic [TAG_W-1:0] actTag_reg;
	logic [DBTC_DATA_W-1:0] dataOut_reg;
	logic [DBTC_LANES-1:0] parityOut_reg;
	logic dataOe_reg;
	logic parityOe_reg;
	logic dataBusyOutN_reg;
	logic dataBusyOe_reg;
	logic [DBTC_DATA_W-1:0] rdData_reg;
	logic rdValid_reg;
	logic rdRetry_reg;
	logic lastRdAck_reg;
	logic tenureDone_reg;
	logic tenureErr_reg;
	logic tenureRetry_reg;
	logic checkstop_reg;
	logic [DBTC_LANES-1:0] genPar;
	logic [DBTC_LANES-1:0] laneErr;
	logic qualGrant;
	logic push;
	logic wrFound;
	int unsigned wrSel;
	int unsigned selIdx;
	logic nextWrFound;
	logic [TAG_W-1:0] nextWrTag;
	logic ack;
	logic lastBeat;
	logic finalAck;
	logic abortErr;
	logic abortRetry;

	dbtc_lane_parity #(
		.LANES(DBTC_LANES),
		.LANE_W(DBTC_LANE_W)
	) uParity (
		.genData(coreWrData),
		.chkData(dataIn),
		.chkPar(parityIn),
		.genPar(genPar),
		.laneErr(laneErr)
	);

	// queue entries exist only after a transfer start
	assign qualGrant = state_reg == DBTC_IDLE && valid_reg[0] && !busIn.grantN
		&& busIn.busyN && busIn.dataRetryN && busIn.addrRetryN;
	assign push = !busIn.startN && coreTsMine && !valid_reg[QDEPTH-1];
	assign ack = state_reg == DBTC_BUSY && !busIn.ackN;
	assign lastBeat = beat_reg == (actBurst_reg ? DBTC_BURST_LAST : DBTC_SINGLE_LAST);
	assign abortErr = state_reg == DBTC_BUSY && !busIn.errAckN;
	assign abortRetry = state_reg == DBTC_BUSY && !busIn.addrRetryN && busIn.errAckN;
	assign finalAck = ack && lastBeat && !abortErr && !abortRetry;

	// oldest pending write, for out-of-order write tenures
	always_comb begin
		wrFound = 1'b0;
		wrSel = 0;
		for (int i = QDEPTH - 1; i >= 0; i--) begin
			if (valid_reg[i] && ent_reg[i].isWrite) begin
				wrFound = 1'b1;
				wrSel = i;
			end
		end
	end

	// permit sampled only on the qualified grant edge
	always_comb begin
		selIdx = 0;
		if (!busIn.writeOnlyN && wrFound) begin
			selIdx = wrSel;
		end
	end // head entry otherwise keeps address order

	// remove the granted entry, compacting the queue
	for (genvar i = 0; i < QDEPTH; i++) begin : gShift
		if (i < QDEPTH - 1) begin : gMid
			assign shV[i] = (qualGrant && i >= selIdx) ? valid_reg[i+1] : valid_reg[i];
			assign shE[i] = (qualGrant && i >= selIdx) ? ent_reg[i+1] : ent_reg[i];
		end else begin : gTop
			assign shV[i] = (qualGrant && i >= selIdx) ? 1'b0 : valid_reg[i];
			assign shE[i] = ent_reg[i];
		end
	end

	// append the new transfer start at the first free slot
	for (genvar i = 0; i < QDEPTH; i++) begin : gPush
		logic slotHere;
		if (i == 0) begin : gFirst
			assign slotHere = push && !shV[i];
		end else begin : gRest
			assign slotHere = push && !shV[i] && shV[i-1];
		end
		assign valid_next[i] = shV[i] || slotHere;
		assign ent_next[i] = slotHere ? dbtc_ent_t'{coreTsWrite, coreTsBurst, coreTag} : shE[i];
	end

	always_comb begin
		nextWrFound = 1'b0;
		nextWrTag = ent_next[0].tag;
		for (int i = QDEPTH - 1; i >= 0; i--) begin
			if (valid_next[i] && ent_next[i].isWrite) begin
				nextWrFound = 1'b1;
				nextWrTag = ent_next[i].tag;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			valid_reg <= '0;
		end else begin
			valid_reg <= valid_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < QDEPTH; i++) begin
			ent_reg[i] <= ent_next[i];
		end
	end

	// tenure sequencing
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= DBTC_IDLE;
			actWrite_reg <= 1'b0;
			actBurst_reg <= 1'b0;
			actTag_reg <= '0;
			beat_reg <= DBTC_BEAT_FIRST;
		end else begin
			case (state_reg)
				DBTC_IDLE: begin
					if (qualGrant) begin
						state_reg <= DBTC_BUSY;
						actWrite_reg <= ent_reg[selIdx].isWrite;
						actBurst_reg <= ent_reg[selIdx].isBurst;
						actTag_reg <= ent_reg[selIdx].tag;
						beat_reg <= DBTC_BEAT_FIRST;
					end
				end
				DBTC_BUSY: begin
					if (abortErr || abortRetry || finalAck) begin
						state_reg <= DBTC_RELEASE;
					end else if (ack) begin
						beat_reg <= beat_reg + DBTC_BEAT_STEP;
					end
				end
				DBTC_RELEASE: begin
					state_reg <= DBTC_IDLE;
				end
				default: begin
					state_reg <= DBTC_IDLE;
				end
			endcase
		end
	end

	// busy: driven low in tenure, high one cycle, then released
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			dataBusyOutN_reg <= 1'b1;
			dataBusyOe_reg <= 1'b0;
		end else begin
			dataBusyOutN_reg <= !(qualGrant || (state_reg == DBTC_BUSY
				&& !abortErr && !abortRetry && !finalAck));
			dataBusyOe_reg <= qualGrant || state_reg == DBTC_BUSY;
		end
	end

	// write data: beat with busy, advance after each ack but the last
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			dataOut_reg <= DBTC_DATA_RST;
			parityOut_reg <= DBTC_PAR_RST;
			dataOe_reg <= 1'b0;
			parityOe_reg <= 1'b0;
		end else begin
			if ((qualGrant && ent_reg[selIdx].isWrite)
				|| (ack && actWrite_reg && !lastBeat)) begin
				// every lane passes whatever the core holds
				dataOut_reg <= coreWrData;
				parityOut_reg <= genPar;
			end
			if (qualGrant) begin
				dataOe_reg <= ent_reg[selIdx].isWrite && busIn.disableN;
			end else if (state_reg == DBTC_BUSY && actWrite_reg && !abortErr
				&& !abortRetry && !finalAck) begin
				dataOe_reg <= busIn.disableN;
			end else begin
				dataOe_reg <= 1'b0;
			end
			if (qualGrant) begin
				parityOe_reg <= ent_reg[selIdx].isWrite && busIn.disableN && parityGenEn;
			end else if (state_reg == DBTC_BUSY && actWrite_reg && !abortErr
				&& !abortRetry && !finalAck) begin
				parityOe_reg <= busIn.disableN && parityGenEn;
			end else begin
				parityOe_reg <= 1'b0;
			end
		end
	end

	// beat the core must present on coreWrData
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wrTag_reg <= '0;
			wrBeat_reg <= DBTC_BEAT_FIRST;
		end else if (qualGrant) begin
			wrTag_reg <= ent_reg[selIdx].tag;
			wrBeat_reg <= DBTC_BEAT_STEP;
		end else if (state_reg == DBTC_BUSY) begin
			if (ack && actWrite_reg && !lastBeat) begin
				wrBeat_reg <= wrBeat_reg + DBTC_BEAT_STEP;
			end
		end else begin
			wrTag_reg <= nextWrFound ? nextWrTag : wrTag_reg;
			wrBeat_reg <= DBTC_BEAT_FIRST;
		end
	end

	// reads: capture with ack, retry the cycle after
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdData_reg <= DBTC_DATA_RST;
			rdValid_reg <= 1'b0;
			rdRetry_reg <= 1'b0;
			lastRdAck_reg <= 1'b0;
		end else begin
			rdValid_reg <= ack && !actWrite_reg && !abortErr;
			lastRdAck_reg <= ack && !actWrite_reg && !abortErr;
			rdRetry_reg <= lastRdAck_reg && !busIn.dataRetryN;
			if (ack && !actWrite_reg) begin
				rdData_reg <= dataIn;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			checkstop_reg <= 1'b0;
		end else if (ack && !actWrite_reg && parityChkEn && |laneErr) begin
			checkstop_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tenureDone_reg <= 1'b0;
			tenureErr_reg <= 1'b0;
			tenureRetry_reg <= 1'b0;
		end else begin
			tenureDone_reg <= finalAck;
			tenureErr_reg <= abortErr;
			tenureRetry_reg <= abortRetry;
		end
	end

	assign dataOut = dataOut_reg;
	assign parityOut = parityOut_reg;
	assign dataOe = dataOe_reg;
	assign parityOe = parityOe_reg;
	assign dataBusyOutN = dataBusyOutN_reg;
	assign dataBusyOe = dataBusyOe_reg;
	assign wrTag = wrTag_reg;
	assign wrBeat = wrBeat_reg;
	assign actTag = actTag_reg;
	assign rdData = rdData_reg;
	assign rdValid = rdValid_reg;
	assign rdRetry = rdRetry_reg;
	assign tenureDone = tenureDone_reg;
	assign tenureErr = tenureErr_reg;
	assign tenureRetry = tenureRetry_reg;
	assign queueFull = valid_reg[QDEPTH-1];
	assign checkstop = checkstop_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence seqFinal;
		finalAck;
	endsequence
	sequence seqDriveHigh;
		dataBusyOe && dataBusyOutN && !dataOe;
	endsequence

	AST_GRANT_QUAL: assert property (
		state_reg == DBTC_IDLE && (!busIn.busyN || !busIn.dataRetryN || !busIn.addrRetryN)
		|=> state_reg == DBTC_IDLE) else $error("grant taken while not qualified");
	AST_NO_GRANT: assert property (
		state_reg == DBTC_IDLE && busIn.grantN |=> dataBusyOutN && state_reg == DBTC_IDLE)
		else $error("tenure started without grant");
	AST_NEED_TS: assert property (
		state_reg == DBTC_IDLE && !valid_reg[0] |=> state_reg == DBTC_IDLE)
		else $error("tenure started with nothing pending");
	AST_ORDER: assert property (
		qualGrant && busIn.writeOnlyN |=> actWrite_reg == $past(ent_reg[0].isWrite))
		else $error("tenure out of address order");
	AST_WRITE_JUMP: assert property (
		qualGrant && !busIn.writeOnlyN && wrFound |=> actWrite_reg && !dataBusyOutN)
		else $error("permitted write not taken");
	AST_BUSY_NEXT: assert property (
		qualGrant |=> !dataBusyOutN && dataBusyOe && state_reg == DBTC_BUSY)
		else $error("busy not asserted after grant");
	AST_RELEASE: assert property (
		seqFinal |=> seqDriveHigh ##1 !dataBusyOe) else $error("busy release wrong");
	AST_FLOAT_ERR: assert property (
		abortErr |=> !dataOe && !parityOe ##1 !dataBusyOe) else $error("bus not floated");
	AST_SINGLE: assert property (
		state_reg == DBTC_BUSY && !actBurst_reg && ack |=> state_reg == DBTC_RELEASE)
		else $error("single beat tenure not ended");
	AST_WR_STEP: assert property (
		ack && actWrite_reg && !lastBeat && !abortErr && !abortRetry
		|=> wrBeat_reg == $past(wrBeat_reg) + DBTC_BEAT_STEP && state_reg == DBTC_BUSY)
		else $error("write beat not advanced");
	AST_DISABLE: assert property (
		state_reg == DBTC_BUSY && actWrite_reg && !busIn.disableN
		|=> !dataOe && !parityOe && dataBusyOe) else $error("disable not honoured");
	AST_RD_NO_DRIVE: assert property (
		state_reg == DBTC_BUSY && !actWrite_reg |=> !dataOe)
		else $error("read tenure drove data");
	AST_PARITY: assert property (
		parityOe |-> ^{dataOut, parityOut} == 1'b0 && dataOe) else $error("bad write parity");
	AST_CHECKSTOP: assert property (
		ack && !actWrite_reg && parityChkEn && |laneErr |=> checkstop [*2])
		else $error("parity error missed");
endmodule : dbtc_tenure

// *** test/dbtc_mem_model.sv ***
`timescale 1ns/1ns
module dbtc_mem_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic busyWireN,
	input wire logic [1:0] waitCycles,
	input wire logic badParity,
	input wire logic [63:0] rdWord,
	output logic ackN,
	output logic [63:0] dataIn,
	output logic [7:0] parityIn
);
	logic ackReg;
	logic [1:0] waitReg;
	logic [1:0] beatReg;
	logic [63:0] lastReg;
	// one ack per beat after waitCycles + 1 wait states
	always_ff @(posedge sys_clk) begin
		if (sys_rst || busyWireN || !ackN) begin
			ackReg <= 1'b0;
			waitReg <= waitCycles;
		end else if (waitReg != 2'h0) begin
			waitReg <= waitReg - 2'h1;
		end else begin
			ackReg <= 1'b1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst || busyWireN) begin
			beatReg <= 2'h0;
		end else if (!ackN) begin
			beatReg <= beatReg + 2'h1;
		end
		lastReg <= dataIn;
	end
	assign ackN = !(ackReg && !busyWireN);
	// valid only with the ack, inverted garbage otherwise
	assign dataIn = ackN ? ~lastReg : (rdWord ^ {62'h0, beatReg});
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			parityIn[k] = ~^dataIn[63-8*k -: 8] ^ (badParity && k == 0);
		end
	end
endmodule : dbtc_mem_model

// *** test/testbench.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
	import dbtc_pkg::*;
	logic sys_clk, sys_rst, grantN, writeOnlyN, extBusyN, dataRetryN, addrRetryN;
	logic startN, errAckN, disableN, ackN, busyWireN, coreTsMine, coreTsWrite, coreTsBurst;
	logic parityGenEn, parityChkEn, badParity, dataOe, parityOe, dataBusyOutN, dataBusyOe;
	logic rdValid, tenureDone, tenureErr, tenureRetry, checkstop, rdRetry, queueFull;
	logic [1:0] waitCycles, wrBeat;
	logic [3:0] coreTag, wrTag, actTag;
	logic [7:0] parityOut, memPar;
	logic [63:0] dataOut, rdData, memData, rdWord, coreWrData;
	dbtc_busin_t busIn;
	int n_fail, checks_done;
	function automatic logic [63:0] wdat(input logic [3:0] t, input logic [1:0] b);
		return {56'h0123456789abcd, t, 2'h0, b};
	endfunction : wdat
	function automatic logic [7:0] opar(input logic [63:0] d);
		for (int k = 0; k < 8; k++) opar[k] = ~^d[63-8*k -: 8];
	endfunction : opar
	assign coreWrData = wdat(wrTag, wrBeat);
	assign busyWireN = extBusyN & (dataBusyOe ? dataBusyOutN : 1'b1);
	assign busIn = {grantN, writeOnlyN, busyWireN, dataRetryN, addrRetryN, startN, ackN,
		errAckN, disableN};
	dbtc_tenure dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .busIn(busIn),
		.dataIn(dataOe ? dataOut : memData), .parityIn(parityOe ? parityOut : memPar),
		.dataOut(dataOut), .dataOe(dataOe), .parityOut(parityOut), .parityOe(parityOe),
		.dataBusyOutN(dataBusyOutN), .dataBusyOe(dataBusyOe), .coreTsMine(coreTsMine),
		.coreTsWrite(coreTsWrite), .coreTsBurst(coreTsBurst), .coreTag(coreTag),
		.coreWrData(coreWrData), .parityGenEn(parityGenEn), .parityChkEn(parityChkEn),
		.wrTag(wrTag), .wrBeat(wrBeat), .actTag(actTag), .rdData(rdData), .rdValid(rdValid),
		.rdRetry(rdRetry), .tenureDone(tenureDone), .tenureErr(tenureErr),
		.tenureRetry(tenureRetry), .queueFull(queueFull), .checkstop(checkstop));
	dbtc_mem_model mem_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .busyWireN(busyWireN),
		.waitCycles(waitCycles), .badParity(badParity), .rdWord(rdWord), .ackN(ackN),
		.dataIn(memData), .parityIn(memPar));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic queue_one(input logic w, input logic b, input logic [3:0] t);
		@(posedge sys_clk);
		startN <= 1'b0;
		coreTsMine <= 1'b1;
		coreTsWrite <= w;
		coreTsBurst <= b;
		coreTag <= t;
		@(posedge sys_clk);
		startN <= 1'b1;
		coreTsMine <= 1'b0;
	endtask : queue_one
	task automatic give_grant(input logic [3:0] t);
		@(posedge sys_clk);
		grantN <= 1'b0;
		@(posedge sys_clk);
		grantN <= 1'b1;
		@(negedge sys_clk);
		`CHK(dataBusyOutN, 1'b0)
		`CHK(dataBusyOe, 1'b1)
		`CHK(actTag, t)
	endtask : give_grant
	task automatic wait_ack();
		int i;
		i = 0;
		@(negedge sys_clk);
		while (ackN !== 1'b0 && i < 40) begin
			@(negedge sys_clk);
			i++;
		end
		`CHK(ackN, 1'b0)
	endtask : wait_ack
	task automatic run_beats(input int n, input logic w, input logic [3:0] t);
		for (int b = 0; b < n; b++) begin
			wait_ack();
			if (w) begin
				`CHK(dataOut, wdat(t, b[1:0]))
				`CHK(parityOut, opar(wdat(t, b[1:0])))
				`CHK(parityOe, parityGenEn)
			end else begin
				`CHK(dataOe, 1'b0)
			end
			@(negedge sys_clk);
			if (!w) begin
				`CHK(rdValid, 1'b1)
				`CHK(rdData, rdWord ^ 64'(b))
			end
		end
		`CHK(tenureDone, 1'b1)
		`CHK(dataBusyOe, 1'b1)
		`CHK(busyWireN, 1'b1)
		`CHK(dataOe, 1'b0)
		@(negedge sys_clk);
		`CHK(dataBusyOe, 1'b0)
	endtask : run_beats
	task automatic t_write(input logic gen, input logic [1:0] w);
		@(posedge sys_clk);
		parityGenEn <= gen;
		waitCycles <= w;
		queue_one(1'b1, 1'b1, 4'h5);
		give_grant(4'h5);
		`CHK(dataOe, 1'b1)
		`CHK(dataOut, wdat(4'h5, 2'h0))
		run_beats(4, 1'b1, 4'h5);
	endtask : t_write
	task automatic t_read(input logic b, input logic bad, input logic chk);
		@(posedge sys_clk);
		badParity <= bad;
		parityChkEn <= chk;
		disableN <= 1'b0;
		queue_one(1'b0, b, 4'h9);
		give_grant(4'h9);
		// single reads see a data retry after their ack
		@(posedge sys_clk);
		dataRetryN <= b;
		run_beats(b ? 4 : 1, 1'b0, 4'h9);
		`CHK(checkstop, bad & chk)
		`CHK(rdRetry, !b)
		@(posedge sys_clk);
		disableN <= 1'b1;
		dataRetryN <= 1'b1;
		badParity <= 1'b0;
	endtask : t_read
	task automatic t_order();
		queue_one(1'b0, 1'b0, 4'h1);
		queue_one(1'b1, 1'b0, 4'h2);
		give_grant(4'h1);
		run_beats(1, 1'b0, 4'h1);
		give_grant(4'h2);
		run_beats(1, 1'b1, 4'h2);
		queue_one(1'b0, 1'b0, 4'h3);
		queue_one(1'b1, 1'b0, 4'h4);
		writeOnlyN <= 1'b0;
		give_grant(4'h4);
		@(posedge sys_clk);
		writeOnlyN <= 1'b1;
		run_beats(1, 1'b1, 4'h4);
		give_grant(4'h3);
		run_beats(1, 1'b0, 4'h3);
		@(posedge sys_clk);
		writeOnlyN <= 1'b0;
		queue_one(1'b0, 1'b0, 4'h6);
		give_grant(4'h6);
		run_beats(1, 1'b0, 4'h6);
		@(posedge sys_clk);
		writeOnlyN <= 1'b1;
	endtask : t_order
	task automatic t_qualify();
		queue_one(1'b1, 1'b0, 4'h7);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			grantN <= (i == 3);
			extBusyN <= (i != 0);
			dataRetryN <= (i != 1);
			addrRetryN <= (i != 2);
			repeat (4) begin
				@(negedge sys_clk);
				`CHK(dataBusyOe, 1'b0)
			end
			@(posedge sys_clk);
			{grantN, extBusyN, dataRetryN, addrRetryN} <= 4'hf;
		end
		give_grant(4'h7);
		run_beats(1, 1'b1, 4'h7);
		@(posedge sys_clk);
		grantN <= 1'b0;
		repeat (5) begin
			@(negedge sys_clk);
			`CHK(dataBusyOe, 1'b0)
		end
		@(posedge sys_clk);
		grantN <= 1'b1;
	endtask : t_qualify
	task automatic t_full();
		// fifth start is dropped while the queue is full
		for (int i = 0; i < 5; i++) begin
			queue_one(1'b0, 1'b0, 4'(i + 11));
			@(negedge sys_clk);
			`CHK(queueFull, i > 2)
		end
		for (int i = 0; i < 4; i++) begin
			give_grant(4'(i + 11));
			run_beats(1, 1'b0, 4'(i + 11));
		end
		`CHK(queueFull, 1'b0)
	endtask : t_full
	task automatic t_abort();
		waitCycles <= 2'h3;
		queue_one(1'b1, 1'b1, 4'h8);
		give_grant(4'h8);
		@(posedge sys_clk);
		disableN <= 1'b0;
		@(posedge sys_clk);
		disableN <= 1'b1;
		errAckN <= 1'b0;
		@(negedge sys_clk);
		`CHK(dataOe, 1'b0)
		`CHK(parityOe, 1'b0)
		`CHK(busyWireN, 1'b0)
		@(posedge sys_clk);
		errAckN <= 1'b1;
		@(negedge sys_clk);
		`CHK(tenureErr, 1'b1)
		`CHK(busyWireN, 1'b1)
		queue_one(1'b1, 1'b0, 4'ha);
		give_grant(4'ha);
		@(posedge sys_clk);
		addrRetryN <= 1'b0;
		@(posedge sys_clk);
		addrRetryN <= 1'b1;
		@(negedge sys_clk);
		`CHK(tenureRetry, 1'b1)
		`CHK(dataOe, 1'b0)
		repeat (2) @(negedge sys_clk);
		`CHK(dataBusyOe, 1'b0)
		waitCycles <= 2'h0;
	endtask : t_abort
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (6000) @(posedge sys_clk);
		n_fail++;
		tally_and_finish();
	end
	initial begin
		n_fail = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		{grantN, writeOnlyN, extBusyN, dataRetryN, addrRetryN, startN, errAckN, disableN} = 8'hff;
		{coreTsMine, coreTsWrite, coreTsBurst, parityChkEn, badParity} = 5'h0;
		parityGenEn = 1'b1;
		coreTag = 4'h0;
		waitCycles = 2'h0;
		rdWord = 64'h0f1e2d3c4b5a6978;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_write(1'b1, 2'h0);
		t_write(1'b0, 2'h2);
		t_read(1'b1, 1'b0, 1'b1);
		t_read(1'b0, 1'b1, 1'b0);
		t_order();
		t_full();
		t_qualify();
		t_abort();
		t_read(1'b0, 1'b1, 1'b1);
		tally_and_finish();
	end
endmodule : testbench
